// >>> cyclic_waker.sv
`timescale 1ns/100ps
module cyclic_waker import rf_addr_pkg::*; #(
  parameter int CHECK = CHECK_CYC
) (
  input  wire logic       ref_clk,
  input  wire logic       rst_b,
  input  wire logic       tick,        // 100 ms step
  input  wire logic       cyc_en,      // Cyclic sleep selected
  input  wire logic       sleep_req,   // Receiver timed out
  input  wire logic [7:0] interval,    // Sleep interval in steps
  input  wire logic       init_seen,   // Initializer heard
  output logic            awake,       // Receiver powered
  output logic            checking     // In a wake check
);
  typedef enum logic [1:0] {W_AWAKE, W_SLEEP, W_CHECK} w_state_t;
  typedef struct packed {
    w_state_t    mode;
    logic [7:0]  steps;                // Steps slept so far
    logic [31:0] win;                  // Cycles into the check
  } cw_t;
  cw_t s_r, s_nxt;

  // ---------------------------------------------------------------
  // Sleep, wake once per interval, stay up on an initializer
  // ---------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    case (s_r.mode)
      W_AWAKE: begin
        s_nxt.steps = 8'h0;
        if (cyc_en && sleep_req) s_nxt.mode = W_SLEEP;
      end
      W_SLEEP: begin
        if (tick) s_nxt.steps = s_r.steps + 8'h1;
        if (tick && (s_r.steps + 8'h1 >= interval)) begin
          s_nxt.mode = W_CHECK;
          s_nxt.win = 32'h0;
        end
      end
      W_CHECK: begin
        s_nxt.win = s_r.win + 32'h1;
        if (init_seen) begin
          s_nxt.mode = W_AWAKE;
        end else if (s_r.win >= 32'(CHECK - 1)) begin
          s_nxt.mode  = W_SLEEP;
          s_nxt.steps = 8'h0;
        end
      end
      default: s_nxt.mode = W_AWAKE;
    endcase
    // Leaving cyclic sleep mode wakes the receiver at once
    if (!cyc_en) s_nxt.mode = W_AWAKE;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) s_r <= '0;
    else        s_r <= s_nxt;
  end

  assign awake    = (s_r.mode != W_SLEEP);
  assign checking = (s_r.mode == W_CHECK);

  property p_init_wakes;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_r.mode == W_CHECK && init_seen && cyc_en) |=> awake && !checking;
  endproperty
  a_init_wakes: assert property (p_init_wakes)
    else $error("initializer seen during check did not wake");

  property p_check_after_interval;
    @(posedge ref_clk) disable iff (!rst_b)
    (s_r.mode == W_SLEEP && cyc_en && tick &&
     s_r.steps + 8'h1 >= interval) |=> checking;
  endproperty
  a_check_after_interval: assert property (p_check_after_interval)
    else $error("no wake check after sleep interval");
endmodule : cyclic_waker

// >>> remote_radio.sv
`timescale 1ns/100ps
module remote_radio import rf_addr_pkg::*; #(
  parameter int TICK = 20            // Cycles per 100 ms step
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        send,       // Send one frame header
  input  wire logic [2:0]  send_ch,    // Channel of that frame
  input  wire logic [15:0] send_val,   // Network value of that frame
  input  wire logic        init_start, // Begin a wake-up initializer
  input  wire logic [7:0]  init_steps, // Its length in steps
  output logic             rx_frame,
  output logic [2:0]       rx_channel,
  output logic [15:0]      rx_net_value,
  output logic             init_seen
);
  // ---------------------------------------------------------------
  // Frame header and initializer of a remote transmitter
  // ---------------------------------------------------------------
  logic [15:0] init_cnt_r;             // Cycles of initializer left

  // Header fields hold only for the frame cycle, then flip to their inverse
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_frame     <= 1'b0;
      rx_channel   <= 3'h0;
      rx_net_value <= 16'h0000;
      init_cnt_r   <= 16'h0000;
    end else begin
      rx_frame <= send;
      if (send) begin
        rx_channel   <= send_ch;
        rx_net_value <= send_val;
      end else if (rx_frame) begin
        // Released lines show the inverse, never the old value
        rx_channel   <= ~rx_channel;
        rx_net_value <= ~rx_net_value;
      end
      // Initializer length is set by the bench above the interval
      if (init_start) begin
        init_cnt_r <= 16'(init_steps) * 16'(TICK);
      end else if (init_cnt_r != 16'h0000) begin
        init_cnt_r <= init_cnt_r - 16'h0001;
      end
    end
  end

  assign init_seen = (init_cnt_r != 16'h0000);
endmodule : remote_radio

// >>> rf_addr_pkg.sv
package rf_addr_pkg;
  // ---------------------------------------------------------------
  // Command codes of the configuration port
  // ---------------------------------------------------------------
  localparam logic [7:0]  CMD_INACT     = 8'h03;  // Inactivity time
  localparam logic [7:0]  CMD_HOP       = 8'h11;  // Hopping channel
  localparam logic [7:0]  CMD_NETID     = 8'h27;  // Network match
  // ---------------------------------------------------------------
  // Field limits and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0]  HOP_MAX       = 3'h6;   // Highest channel
  localparam logic [2:0]  HOP_RST       = 3'h0;   // Channel at reset
  localparam logic [15:0] INACT_RST     = 16'hFFFF;
  localparam logic [15:0] INACT_OFF     = 16'hFFFF; // Disables init
  localparam logic [15:0] NETID_RO_MIN  = 16'h8000; // Factory range
  // Arbitrary neutral factory value
  localparam logic [15:0] NETID_DFLT    = 16'h8A5C;
  localparam logic [1:0]  LEN_HOP       = 2'h1;   // Bytes returned
  localparam logic [1:0]  LEN_WORD      = 2'h2;
  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS    = 50;                  // ref_clk period
  localparam int TICK_MS   = 100;                 // Parameter step
  localparam int TICK_CYC  = TICK_MS * 1000000 / CLK_NS;
  localparam int CHECK_MS  = 35;                  // Wake check window
  localparam int CHECK_CYC = CHECK_MS * 1000000 / CLK_NS;
endpackage : rf_addr_pkg

// >>> rf_addressing_wakeup_init_ctl.sv
// What this block does
// - Hop channel 0-6 at code 0x11, one byte
// - Only same-channel frames are accepted
// - Inactivity time at code 0x03, two bytes
// - Default 0xFFFF, which disables long initializer
// - After inactivity, prefix transmission with initializer
// - Sleeping receiver checks once per interval
// - Initializer seen during check keeps receiver awake
// - Initializer length vs. receivers' sleep interval is not checked; host sets it
// - Network match at 0x27; upper half read-only
// - Frames with other network value are discarded
// - Initializer length from duration parameter, 100 ms
`timescale 1ns/100ps
module rf_addressing_wakeup_init_ctl import rf_addr_pkg::*; #(
  parameter int TICK_CYCLES  = TICK_CYC,   // Cycles per 100 ms
  parameter int CHECK_CYCLES = CHECK_CYC   // Cycles per wake check
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  // Configuration command port
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_code,
  input  wire logic [15:0] cmd_wdata,
  output logic             resp_valid,
  output logic [15:0]      resp_data,
  output logic [1:0]       resp_len,
  output logic             resp_err,
  // Settings owned by neighbouring blocks
  input  wire logic [7:0]  init_duration_param,
  input  wire logic [7:0]  sleep_interval,
  input  wire logic        sleep_select_param,
  input  wire logic        sleep_req,
  // Transmit path
  input  wire logic        tx_start,
  output logic             tx_go,
  output logic             tx_busy,
  output logic             init_on,
  // Receive path
  input  wire logic        rx_frame,
  input  wire logic [2:0]  rx_channel,
  input  wire logic [15:0] rx_net_value,
  input  wire logic        init_seen,
  output logic             rx_accept,
  output logic             rx_drop,
  // Radio control
  output logic [2:0]       hop_channel,
  output logic             radio_awake,
  output logic             wake_check
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [0:0] {TX_IDLE, TX_INIT} tx_state_t;
  typedef struct packed {
    logic [2:0]  hop;          // Hopping channel
    logic [15:0] inact;        // Inactivity time, in steps
    logic [15:0] netid;        // Network match value
    logic [15:0] idle;         // Steps since last activity
    tx_state_t   tx;           // Transmit sequencer
    logic [7:0]  init_left;    // Initializer steps remaining
    logic        resp_valid;
    logic [15:0] resp_data;
    logic [1:0]  resp_len;
    logic        resp_err;
    logic        tx_go;
    logic        rx_accept;
    logic        rx_drop;
    logic        awake;
    logic        check;
  } ctl_t;
  ctl_t c_r, c_nxt;

  logic idle_tick;             // Step of the idle timer
  logic init_tick;             // Step of the initializer timer
  logic activity;              // Any transmit or receive event
  logic init_start;            // Initializer begins this cycle
  logic expired;               // Idle long enough for initializer
  logic w_awake;               // Receiver power from the waker
  logic w_check;

  // ---------------------------------------------------------------
  // Step timers and receiver sleep control
  // ---------------------------------------------------------------
  // Activity realigns the step so idle time is counted from it
  assign activity = tx_start | rx_frame | c_r.tx_go;

  step_ticker #(.CYCLES(TICK_CYCLES)) u_idle_tick (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .restart (activity),
    .tick    (idle_tick)
  );

  // Realigned at start so the initializer lasts whole steps
  step_ticker #(.CYCLES(TICK_CYCLES)) u_init_tick (
    .ref_clk (ref_clk),
    .rst_b   (rst_b),
    .restart (init_start),
    .tick    (init_tick)
  );

  cyclic_waker #(.CHECK(CHECK_CYCLES)) u_waker (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .tick      (idle_tick),
    .cyc_en    (sleep_select_param),
    .sleep_req (sleep_req),
    .interval  (sleep_interval),
    .init_seen (init_seen),
    .awake     (w_awake),
    .checking  (w_check)
  );

  // Value 0xFFFF never expires: long initializer switched off
  assign expired = (c_r.inact != INACT_OFF) &&
                   (c_r.idle >= c_r.inact);
  assign init_start = (c_r.tx == TX_IDLE) && tx_start && expired &&
                      (init_duration_param != 8'h0);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    c_nxt            = c_r;
    c_nxt.resp_valid = 1'b0;
    c_nxt.tx_go      = 1'b0;
    c_nxt.rx_accept  = 1'b0;
    c_nxt.rx_drop    = 1'b0;
    c_nxt.awake      = w_awake;
    c_nxt.check      = w_check;

    // Idle counter: cleared by activity, saturates at the top
    if (activity) begin
      c_nxt.idle = 16'h0;
    end else if (idle_tick && c_r.idle != 16'hFFFF) begin
      c_nxt.idle = c_r.idle + 16'h1;
    end

    // Configuration commands, answered on the next cycle
    if (cmd_valid) begin
      c_nxt.resp_valid = 1'b1;
      c_nxt.resp_err   = 1'b0;
      if (cmd_code == CMD_HOP) begin
        c_nxt.resp_len = LEN_HOP;
        if (cmd_write && cmd_wdata > {13'h0, HOP_MAX}) begin
          c_nxt.resp_err = 1'b1;
        end else if (cmd_write) begin
          c_nxt.hop = cmd_wdata[2:0];
        end
        c_nxt.resp_data = {13'h0, c_nxt.hop};
      end else if (cmd_code == CMD_INACT) begin
        c_nxt.resp_len = LEN_WORD;
        if (cmd_write) c_nxt.inact = cmd_wdata;
        c_nxt.resp_data = c_nxt.inact;
      end else if (cmd_code == CMD_NETID) begin
        c_nxt.resp_len = LEN_WORD;
        // The factory range cannot be written by the host
        if (cmd_write && cmd_wdata >= NETID_RO_MIN) begin
          c_nxt.resp_err = 1'b1;
        end else if (cmd_write) begin
          c_nxt.netid = cmd_wdata;
        end
        c_nxt.resp_data = c_nxt.netid;
      end else begin
        // Unknown code: error, no data
        c_nxt.resp_err  = 1'b1;
        c_nxt.resp_len  = 2'h0;
        c_nxt.resp_data = 16'h0;
      end
    end

    // Receive filter on channel and network value
    if (rx_frame) begin
      if (rx_channel == c_r.hop && rx_net_value == c_r.netid) begin
        c_nxt.rx_accept = 1'b1;
      end else begin
        c_nxt.rx_drop = 1'b1;
      end
    end

    // Transmit sequencer; starts during an initializer are ignored
    case (c_r.tx)
      TX_IDLE: begin
        if (init_start) begin
          c_nxt.tx        = TX_INIT;
          c_nxt.init_left = init_duration_param;
        end else if (tx_start) begin
          c_nxt.tx_go = 1'b1;
        end
      end
      TX_INIT: begin
        // Length set by the duration parameter; must exceed the
        // receivers' interval, which the host configures
        if (init_tick) begin
          c_nxt.init_left = c_r.init_left - 8'h1;
          if (c_r.init_left == 8'h1) begin
            c_nxt.tx    = TX_IDLE;
            c_nxt.tx_go = 1'b1;
          end
        end
      end
      default: c_nxt.tx = TX_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      c_r       <= '0;
      c_r.hop   <= HOP_RST;
      c_r.inact <= INACT_RST;
      c_r.netid <= NETID_DFLT;
      c_r.awake <= 1'b1;
    end else begin
      c_r <= c_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Outputs, all from flip-flops
  // ---------------------------------------------------------------
  assign resp_valid  = c_r.resp_valid;
  assign resp_data   = c_r.resp_data;
  assign resp_len    = c_r.resp_len;
  assign resp_err    = c_r.resp_err;
  assign tx_go       = c_r.tx_go;
  assign tx_busy     = (c_r.tx == TX_INIT);
  assign init_on     = (c_r.tx == TX_INIT);
  assign rx_accept   = c_r.rx_accept;
  assign rx_drop     = c_r.rx_drop;
  assign hop_channel = c_r.hop;
  assign radio_awake = c_r.awake;
  assign wake_check  = c_r.check;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_hop_range;
    @(posedge ref_clk) disable iff (!rst_b)
    hop_channel <= HOP_MAX;
  endproperty
  a_hop_range: assert property (p_hop_range)
    else $error("hop channel out of range");

  property p_hop_refuse;
    @(posedge ref_clk) disable iff (!rst_b)
    (cmd_valid && cmd_write && cmd_code == CMD_HOP &&
     cmd_wdata > 16'h0006) |=> resp_err && $stable(hop_channel);
  endproperty
  a_hop_refuse: assert property (p_hop_refuse)
    else $error("bad hop channel write not refused");

  property p_inact_len;
    @(posedge ref_clk) disable iff (!rst_b)
    (cmd_valid && cmd_code == CMD_INACT) |=>
      resp_valid && resp_len == 2'h2 && !resp_err;
  endproperty
  a_inact_len: assert property (p_inact_len)
    else $error("inactivity answer not two bytes");

  property p_off_no_init;
    @(posedge ref_clk) disable iff (!rst_b)
    (c_r.inact == 16'hFFFF && !tx_busy) |=> !init_on;
  endproperty
  a_off_no_init: assert property (p_off_no_init)
    else $error("initializer sent while disabled");

  property p_init_prefix;
    @(posedge ref_clk) disable iff (!rst_b)
    (tx_start && !tx_busy && expired &&
     init_duration_param != 8'h0) |=> init_on && !tx_go;
  endproperty
  a_init_prefix: assert property (p_init_prefix)
    else $error("expired idle did not start initializer");

  property p_netid_ro;
    @(posedge ref_clk) disable iff (!rst_b)
    (cmd_valid && cmd_write && cmd_code == CMD_NETID &&
     cmd_wdata >= 16'h8000) |=> resp_err && $stable(c_r.netid);
  endproperty
  a_netid_ro: assert property (p_netid_ro)
    else $error("factory network value overwritten");

  property p_rx_filter;
    @(posedge ref_clk) disable iff (!rst_b)
    (rx_frame && rx_net_value != c_r.netid) |=> rx_drop && !rx_accept;
  endproperty
  a_rx_filter: assert property (p_rx_filter)
    else $error("foreign network frame accepted");

  property p_idle_restart;
    @(posedge ref_clk) disable iff (!rst_b)
    activity |=> c_r.idle == 16'h0;
  endproperty
  a_idle_restart: assert property (p_idle_restart)
    else $error("idle timer not restarted");

  property p_rx_channel;
    @(posedge ref_clk) disable iff (!rst_b)
    (rx_frame && rx_channel != c_r.hop) |=> rx_drop && !rx_accept;
  endproperty
  a_rx_channel: assert property (p_rx_channel)
    else $error("frame on another channel accepted");

  // Last initializer step must hand over to the data at once
  property p_init_ends_go;
    @(posedge ref_clk) disable iff (!rst_b)
    (init_on && init_tick && c_r.init_left == 8'h1) |=> tx_go && !init_on;
  endproperty
  a_init_ends_go: assert property (p_init_ends_go)
    else $error("initializer did not hand over to data");
endmodule : rf_addressing_wakeup_init_ctl

// >>> step_ticker.sv
`timescale 1ns/100ps
module step_ticker import rf_addr_pkg::*; #(
  parameter int CYCLES = TICK_CYC
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic restart,   // Realign the step to now
  output logic      tick       // One pulse per step
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] cnt;          // Cycles into the current step
    logic        tick;
  } tk_t;
  tk_t tk_r, tk_nxt;

  // Count cycles, pulse at the end of each step
  always_comb begin
    tk_nxt      = tk_r;
    tk_nxt.tick = 1'b0;
    if (restart) begin
      tk_nxt.cnt = 32'h0;
    end else if (tk_r.cnt >= 32'(CYCLES - 1)) begin
      tk_nxt.cnt  = 32'h0;
      tk_nxt.tick = 1'b1;
    end else begin
      tk_nxt.cnt = tk_r.cnt + 32'h1;
    end
  end

  // Register the state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) tk_r <= '0;
    else        tk_r <= tk_nxt;
  end

  assign tick = tk_r.tick;
endmodule : step_ticker

// >>> tb_rf_addressing_wakeup_init_ctl.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin error_cnt++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (b)); end end
module tb_rf_addressing_wakeup_init_ctl import rf_addr_pkg::*;;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam int TK = 20;              // Short step for simulation
  logic ref_clk, rst_b, cmd_valid, cmd_write, resp_valid, resp_err;
  logic [7:0] cmd_code, init_duration_param, sleep_interval, init_steps;
  logic [15:0] cmd_wdata, resp_data, rx_net_value, send_val;
  logic [1:0] resp_len;
  logic sleep_select_param, sleep_req, tx_start, tx_go, tx_busy, init_on;
  logic rx_frame, init_seen, rx_accept, rx_drop, radio_awake, wake_check;
  logic [2:0] rx_channel, hop_channel, send_ch;
  logic send, init_start;
  int error_cnt = 0;                   // Mismatches seen
  int n_tests = 0;                     // Comparisons made
  int n;                               // Wait loop counter

  rf_addressing_wakeup_init_ctl #(.TICK_CYCLES(TK), .CHECK_CYCLES(5))
  rf_addressing_wakeup_init_ctl_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata),
    .resp_valid(resp_valid), .resp_data(resp_data), .resp_len(resp_len),
    .resp_err(resp_err), .init_duration_param(init_duration_param),
    .sleep_interval(sleep_interval), .sleep_req(sleep_req),
    .sleep_select_param(sleep_select_param), .tx_start(tx_start),
    .tx_go(tx_go), .tx_busy(tx_busy), .init_on(init_on),
    .rx_frame(rx_frame), .rx_channel(rx_channel),
    .rx_net_value(rx_net_value), .init_seen(init_seen),
    .rx_accept(rx_accept), .rx_drop(rx_drop), .hop_channel(hop_channel),
    .radio_awake(radio_awake), .wake_check(wake_check));

  remote_radio #(.TICK(TK)) remote_radio_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .send(send), .send_ch(send_ch),
    .send_val(send_val), .init_start(init_start),
    .init_steps(init_steps), .rx_frame(rx_frame),
    .rx_channel(rx_channel), .rx_net_value(rx_net_value),
    .init_seen(init_seen));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  // Inputs move 1 ns after the edge so sampling never races
  task automatic step();
    @(posedge ref_clk);
    #1;
  endtask : step

  task automatic report_and_stop();
    $display("errors %0d of %0d checks", error_cnt, n_tests);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : report_and_stop

  // A wait that used its whole bound ends the run
  task automatic bound(input int cnt, input int lim);
    if (cnt >= lim) begin
      error_cnt++;
      $display("[ERR] %0t wait ran out", $time);
      report_and_stop();
    end
  endtask : bound

  // One command, then its answer one cycle later
  task automatic cmd(input logic w, input logic [7:0] c,
                     input logic [15:0] d, input logic [15:0] ed,
                     input logic [1:0] el, input logic ee);
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code  = c;
    cmd_wdata = d;
    step();
    cmd_valid = 1'b0;
    `CHK(resp_valid, 1'b1)
    `CHK(resp_data, ed)
    `CHK(resp_len, el)
    `CHK(resp_err, ee)
    // Let an edge pass so the next strobe is a fresh one
    step();
  endtask : cmd

  // Remote frame through the partner, verdict two cycles on
  task automatic frame(input logic [2:0] c, input logic [15:0] v,
                       input logic acc);
    send     = 1'b1;
    send_ch  = c;
    send_val = v;
    step();
    send = 1'b0;
    step();
    `CHK({rx_accept, rx_drop}, {acc, ~acc})
  endtask : frame

  task automatic kick();
    tx_start = 1'b1;
    step();
    tx_start = 1'b0;
  endtask : kick

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic sc_regs();
    `CHK(hop_channel, 3'h0)
    cmd(1'b0, CMD_INACT, 16'h0000, 16'hFFFF, 2'h2, 1'b0);
    cmd(1'b0, CMD_HOP, 16'h0000, 16'h0000, 2'h1, 1'b0);
    cmd(1'b0, CMD_NETID, 16'h0000, 16'h8A5C, 2'h2, 1'b0);
    cmd(1'b0, 8'h55, 16'h0000, 16'h0000, 2'h0, 1'b1);
    cmd(1'b1, CMD_HOP, 16'h0006, 16'h0006, 2'h1, 1'b0);
    `CHK(hop_channel, 3'h6)
    cmd(1'b1, CMD_HOP, 16'h0007, 16'h0006, 2'h1, 1'b1);
    cmd(1'b1, CMD_NETID, 16'h8000, 16'h8A5C, 2'h2, 1'b1);
    cmd(1'b1, CMD_NETID, 16'h7FFF, 16'h7FFF, 2'h2, 1'b0);
    cmd(1'b0, CMD_NETID, 16'h0000, 16'h7FFF, 2'h2, 1'b0);
  endtask : sc_regs

  task automatic sc_rx();
    frame(3'h6, 16'h7FFF, 1'b1);
    frame(3'h5, 16'h7FFF, 1'b0);
    frame(3'h6, 16'h7FFE, 1'b0);
  endtask : sc_rx

  task automatic sc_tx();
    // Host sets idle time equal to the receivers' one-step timeout
    cmd(1'b1, CMD_INACT, 16'h0001, 16'h0001, 2'h2, 1'b0);
    init_duration_param = 8'h02;
    frame(3'h6, 16'h7FFF, 1'b1);
    kick();
    `CHK({tx_go, init_on}, 2'b10)
    repeat (50) step();
    kick();
    `CHK({tx_go, init_on, tx_busy}, 3'b011)
    step();
    kick();
    for (n = 1; n < 100 && tx_go !== 1'b1; n++) step();
    bound(n, 100);
    `CHK(n >= 2 * TK && n <= 2 * TK + 1, 1'b1)
    `CHK(init_on, 1'b0)
    step();
    `CHK(tx_go, 1'b0)
    cmd(1'b1, CMD_INACT, 16'hFFFF, 16'hFFFF, 2'h2, 1'b0);
    repeat (60) step();
    kick();
    `CHK({tx_go, init_on}, 2'b10)
  endtask : sc_tx

  task automatic sc_sleep();
    sleep_interval     = 8'h02;
    sleep_select_param = 1'b1;
    sleep_req          = 1'b1;
    step();
    sleep_req = 1'b0;
    for (n = 0; n < 10 && radio_awake !== 1'b0; n++) step();
    bound(n, 10);
    for (n = 0; n < 3 * TK && wake_check !== 1'b1; n++) step();
    bound(n, 3 * TK);
    `CHK(n >= TK, 1'b1)
    for (n = 0; n < 20 && wake_check !== 1'b0; n++) step();
    bound(n, 20);
    repeat (3) step();
    `CHK(radio_awake, 1'b0)
    for (n = 0; n < 3 * TK && wake_check !== 1'b1; n++) step();
    bound(n, 3 * TK);
    init_start = 1'b1;
    step();
    init_start = 1'b0;
    repeat (12) step();
    `CHK(radio_awake, 1'b1)
    repeat (60) step();
    `CHK(radio_awake, 1'b1)
    sleep_select_param = 1'b0;
  endtask : sc_sleep

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (50000) @(posedge ref_clk);
    bound(1, 1);
  end

  initial begin
    {rst_b, cmd_valid, cmd_write, sleep_select_param, sleep_req} = '0;
    {tx_start, send, init_start, cmd_code, cmd_wdata} = '0;
    {sleep_interval, send_ch, send_val} = '0;
    init_duration_param = 8'h01;
    init_steps          = 8'h03;
    repeat (6) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    sc_regs();
    sc_rx();
    sc_tx();
    sc_sleep();
    report_and_stop();
  end
endmodule : tb_rf_addressing_wakeup_init_ctl
